//--- rtl/prl_defines.svh
// Constants for the protected register lock and oscillator trim block.
// Assumes inclusion by bare name from rtl/ and verification/ files.
`ifndef PRL_DEFINES_SVH
`define PRL_DEFINES_SVH

`define PRL_OFF_LOCK_KEY     12'h100
`define PRL_OFF_OSC_TRIM     12'h110
`define PRL_ADDR_W           12
`define PRL_KEY_FIRST        8'h59
`define PRL_KEY_SECOND       8'h16
`define PRL_KEY_THIRD        8'h88
`define PRL_KEY_MSB          7
`define PRL_KEY_LSB          0
`define PRL_TRIM_SET0_LSB    0
`define PRL_TRIM_SET0_MSB    7
`define PRL_RANGE_SET0_BIT   8
`define PRL_TRIM_SET1_LSB    16
`define PRL_TRIM_SET1_MSB    23
`define PRL_RANGE_SET1_BIT   24
`define PRL_COARSE_MSB       7
`define PRL_COARSE_LSB       5
`define PRL_FINE_MSB         4
`define PRL_FINE_LSB         0
`define PRL_TRIM_WMASK       32'h01FF01FF
`define PRL_HTRANS_NONSEQ    2'h2
`define PRL_HRESP_OKAY       1'h0

`endif

//--- rtl/prl_lock_trim.sv
// Protected register lock with key sequence, and the protected oscillator trim register.
// Assumes one AHB-Lite master, mclk at 250 MHz, factory trim word valid at the first edge after reset.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "prl_defines.svh"
//
// Behaviour
// - Protected registers locked from reset onward
// - Keys 59h,16h,88h in order unlock
// - Bad value, order or address aborts
// - Lock key read bit0 shows unlocked
// - Any lock key write while open locks
// - Locked writes to protected registers dropped
// - Trim register writable only while unlocked
// - First edge after reset loads both trim sets from flash
// - Trim codes at bits 7:0, 23:16
// - Code bits 7:5 coarse, 4:0 fine
// - Range bits 8 and 24, one low
module prl_lock_trim
  import prl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] factory_trim,
  input  wire logic        osc_trim_set_select,
  output logic             unlock_state,
  output logic      [2:0]  osc_coarse,
  output logic      [4:0]  osc_fine,
  output logic             osc_low_range
);
  logic                     wr_pend;     // Write data phase pending
  logic [`PRL_ADDR_W-1:0]   wr_addr;     // Latched write address
  logic                     wr_hit_key;  // Pending write targets lock key
  logic                     wr_hit_trim; // Pending write targets trim
  logic [31:0]              osc_trim_ctrl; // Trim register contents
  logic                     trim_loaded; // Factory load done after reset
  prl_key_state_t           key_state;   // Key sequence tracker
  prl_key_state_t           next_key_state; // Next tracker state
  logic                     next_unlock; // Next lock state
  logic [7:0]               wbyte;       // Low byte of write data
  logic                     addr_phase;  // Valid address phase this cycle
  logic [7:0]               code_first;  // First trim set code
  logic [7:0]               code_second; // Second trim set code

  // Decode a 12-bit byte offset to a register match
  function automatic logic hit(input logic [`PRL_ADDR_W-1:0] a,
                               input logic [`PRL_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign addr_phase  = hsel && hready && htrans == `PRL_HTRANS_NONSEQ;
  assign wr_hit_key  = hit(wr_addr, `PRL_OFF_LOCK_KEY);
  assign wr_hit_trim = hit(wr_addr, `PRL_OFF_OSC_TRIM);
  assign wbyte       = hwdata[`PRL_KEY_MSB:`PRL_KEY_LSB];
  assign code_first  = osc_trim_ctrl[`PRL_TRIM_SET0_MSB:`PRL_TRIM_SET0_LSB];
  assign code_second = osc_trim_ctrl[`PRL_TRIM_SET1_MSB:`PRL_TRIM_SET1_LSB];

  // Capture write address phases; single-cycle data phase follows
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wr_pend <= 1'h0;
      wr_addr <= '0;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      if (addr_phase)
      begin
        wr_addr <= haddr[`PRL_ADDR_W-1:0];
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'h1;
      hresp     <= `PRL_HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'h1;
      hresp     <= `PRL_HRESP_OKAY;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      hrdata <= 32'h0;
    end
    else if (addr_phase && !hwrite)
    begin
      if (hit(haddr[`PRL_ADDR_W-1:0], `PRL_OFF_LOCK_KEY))
      begin
        hrdata <= {31'h0, unlock_state};
      end
      else if (hit(haddr[`PRL_ADDR_W-1:0], `PRL_OFF_OSC_TRIM))
      begin
        hrdata <= osc_trim_ctrl & `PRL_TRIM_WMASK;
      end
      else
      begin
        hrdata <= 32'h0;  // Unmapped reads as zero
      end
    end
  end

  // Key tracker and lock next-state
  always_comb
  begin
    next_key_state = key_state;
    next_unlock    = unlock_state;
    if (wr_pend)
    begin
      if (!wr_hit_key)
      begin
        next_key_state = PRL_KEY_IDLE;
      end
      else if (unlock_state)
      begin
        next_unlock    = 1'h0;
        next_key_state = PRL_KEY_IDLE;
      end
      else
      begin
        unique case (key_state)
          PRL_KEY_IDLE:
            next_key_state = (wbyte == `PRL_KEY_FIRST) ? PRL_KEY_GOT1 : PRL_KEY_IDLE;
          PRL_KEY_GOT1:
            next_key_state = (wbyte == `PRL_KEY_SECOND) ? PRL_KEY_GOT2 : PRL_KEY_IDLE;
          PRL_KEY_GOT2:
          begin
            next_key_state = PRL_KEY_IDLE;
            next_unlock    = (wbyte == `PRL_KEY_THIRD);
          end
          default:
            next_key_state = PRL_KEY_IDLE;
        endcase
      end
    end
  end

  // Tracker state register
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      key_state <= PRL_KEY_IDLE;
    end
    else
    begin
      key_state <= next_key_state;
    end
  end

  // Lock state register, locked after reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      unlock_state <= 1'h0;
    end
    else
    begin
      unlock_state <= next_unlock;
    end
  end

  // Trim register: factory load after reset, protected writes after
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      osc_trim_ctrl <= 32'h0;
      trim_loaded   <= 1'h0;
    end
    else if (!trim_loaded)
    begin
      osc_trim_ctrl <= factory_trim & `PRL_TRIM_WMASK;
      trim_loaded   <= 1'h1;
    end
    else if (wr_pend && wr_hit_trim && unlock_state)
    begin
      osc_trim_ctrl <= hwdata & `PRL_TRIM_WMASK;
    end
  end

  // Active set split into oscillator controls
  prl_trim_sel u_sel
  (
    .mclk                (mclk),
    .resetn              (resetn),
    .trim_word           (osc_trim_ctrl),
    .osc_trim_set_select (osc_trim_set_select),
    .coarse              (osc_coarse),
    .fine                (osc_fine),
    .low_range           (osc_low_range)
  );

  // Locked writes never change the trim register
  locked_trim_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_trim && !unlock_state && trim_loaded) |=> $stable(osc_trim_ctrl))
    else $error("trim changed while locked");

  // Full key sequence opens the lock
  unlock_seq_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_key && !unlock_state && key_state == PRL_KEY_GOT2
     && wbyte == `PRL_KEY_THIRD) |=> unlock_state)
    else $error("third key did not unlock");

  // Unlock only from the third-key state
  unlock_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(unlock_state) |-> $past(key_state) == PRL_KEY_GOT2)
    else $error("unlocked without full sequence");

  // Any lock key write while open relocks
  relock_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_key && unlock_state) |=> !unlock_state)
    else $error("lock key write did not relock");

  // Foreign write aborts the sequence
  abort_other_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && !wr_hit_key) |=> key_state == PRL_KEY_IDLE)
    else $error("foreign write kept sequence");

  // Wrong second key returns to start
  abort_value_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_key && !unlock_state && key_state == PRL_KEY_GOT1
     && wbyte != `PRL_KEY_SECOND) |=> key_state == PRL_KEY_IDLE)
    else $error("bad key kept sequence");

  // Unlocked trim write lands in the register on the next cycle
  trim_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_trim && unlock_state && trim_loaded)
    |=> osc_trim_ctrl == ($past(hwdata) & `PRL_TRIM_WMASK))
    else $error("unlocked trim write lost");

  // Selected set drives the fine field
  set_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 osc_fine == ($past(osc_trim_set_select)
      ? $past(code_second[`PRL_FINE_MSB:`PRL_FINE_LSB])
      : $past(code_first[`PRL_FINE_MSB:`PRL_FINE_LSB])))
    else $error("wrong trim set active");

  // Read of the lock key shows lock state
  lock_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (addr_phase && !hwrite && hit(haddr[`PRL_ADDR_W-1:0], `PRL_OFF_LOCK_KEY))
    |=> hrdata == {31'h0, $past(unlock_state)})
    else $error("lock read wrong");

  // Lock opens only after a lock key write
  unlock_source_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(unlock_state) |-> $past(wr_pend) && $past(wr_hit_key))
    else $error("unlocked without key write");

  // First key moves the tracker on
  key_first_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_key && !unlock_state && key_state == PRL_KEY_IDLE
     && wbyte == `PRL_KEY_FIRST) |=> key_state == PRL_KEY_GOT1)
    else $error("first key not taken");

  // Wrong third key stays locked and restarts
  abort_third_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_pend && wr_hit_key && !unlock_state && key_state == PRL_KEY_GOT2
     && wbyte != `PRL_KEY_THIRD) |=> !unlock_state && key_state == PRL_KEY_IDLE)
    else $error("bad third key not refused");

  // Factory word loads on the first edge after reset
  factory_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && !trim_loaded) |=> osc_trim_ctrl == ($past(factory_trim) & `PRL_TRIM_WMASK))
    else $error("factory trim not loaded");

  // Trim read returns the stored writable bits
  trim_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (addr_phase && !hwrite && hit(haddr[`PRL_ADDR_W-1:0], `PRL_OFF_OSC_TRIM))
    |=> hrdata == ($past(osc_trim_ctrl) & `PRL_TRIM_WMASK))
    else $error("trim read wrong");

  // Selected set drives the coarse field
  coarse_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 osc_coarse == ($past(osc_trim_set_select)
      ? $past(code_second[`PRL_COARSE_MSB:`PRL_COARSE_LSB])
      : $past(code_first[`PRL_COARSE_MSB:`PRL_COARSE_LSB])))
    else $error("wrong coarse field active");

  // Selected set drives the range bit
  range_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 osc_low_range == ($past(osc_trim_set_select)
      ? $past(osc_trim_ctrl[`PRL_RANGE_SET1_BIT])
      : $past(osc_trim_ctrl[`PRL_RANGE_SET0_BIT])))
    else $error("wrong range bit active");
endmodule

//--- rtl/prl_pkg.sv
// Types shared by the lock and trim block.
// Assumes prl_defines.svh for the numeric constants.
package prl_pkg;
  // Key tracker states
  typedef enum logic [1:0]
  {
    PRL_KEY_IDLE,
    PRL_KEY_GOT1,
    PRL_KEY_GOT2
  } prl_key_state_t;
endpackage

//--- rtl/prl_trim_sel.sv
// Picks the active oscillator trim set and splits it into fields.
// Assumes a registered trim word and a select level from the clock controller.
`timescale 1ns/1ps
`include "prl_defines.svh"
module prl_trim_sel
  import prl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [31:0] trim_word,
  input  wire logic        osc_trim_set_select,
  output logic      [2:0]  coarse,
  output logic      [4:0]  fine,
  output logic             low_range
);
  logic [7:0] code;   // Active trim code
  logic       rng;    // Active range bit

  // Choose the set by the external select bit
  always_comb
  begin
    if (osc_trim_set_select)
    begin
      code = trim_word[`PRL_TRIM_SET1_MSB:`PRL_TRIM_SET1_LSB];
      rng  = trim_word[`PRL_RANGE_SET1_BIT];
    end
    else
    begin
      code = trim_word[`PRL_TRIM_SET0_MSB:`PRL_TRIM_SET0_LSB];
      rng  = trim_word[`PRL_RANGE_SET0_BIT];
    end
  end

  // Register the split fields so outputs come from flops
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      coarse    <= 3'h0;
      fine      <= 5'h0;
      low_range <= 1'h0;
    end
    else
    begin
      coarse    <= code[`PRL_COARSE_MSB:`PRL_COARSE_LSB];
      fine      <= code[`PRL_FINE_MSB:`PRL_FINE_LSB];
      low_range <= rng;
    end
  end
endmodule

//--- verification/prl_lock_trim_tb.sv
// Self-checking bench for the lock key and oscillator trim block.
// Assumes prl_defines.svh on the include path and one AHB-Lite master (this bench).
`timescale 1ns/1ps
`include "prl_defines.svh"
module tb
  import prl_pkg::*;
;
  logic        mclk;          // 250 MHz system clock
  logic        resetn;        // Synchronous reset, low active
  logic        hsel;          // Slave select
  logic [31:0] haddr;         // Byte address
  logic [1:0]  htrans;        // Transfer kind
  logic        hwrite;        // Write when high
  logic [2:0]  hsize;         // Always a word
  logic [31:0] hwdata;        // Write data
  logic [31:0] hrdata;        // Read data
  logic        hreadyout;     // Slave ready, also the bus ready
  logic        hresp;         // Response code
  logic [31:0] factory_trim;  // Factory trim word
  logic        osc_sel;       // Trim set select
  logic        unlock_state;  // Lock status
  logic [2:0]  osc_coarse;    // Active coarse range
  logic [4:0]  osc_fine;      // Active fine step
  logic        osc_low_range; // Active range bit
  int          err_total;     // Mismatches
  int          n_tests;       // Comparisons
  int          cycles;        // Clock cycles run
  localparam logic [11:0] LK = `PRL_OFF_LOCK_KEY; // Lock key offset
  localparam logic [11:0] TR = `PRL_OFF_OSC_TRIM; // Trim offset

  prl_lock_trim u_prl_lock_trim (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .factory_trim(factory_trim), .osc_trim_set_select(osc_sel),
    .unlock_state(unlock_state), .osc_coarse(osc_coarse), .osc_fine(osc_fine),
    .osc_low_range(osc_low_range)
  );

  // Clock generator
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      results();
    end
  end

  // Counts one comparison, reports a mismatch
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single AHB-Lite transfer, waits on ready in both phases
  task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, off};
    htrans <= `PRL_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, `PRL_HRESP_OKAY}, {31'h0, hresp});
  endtask

  // Register write
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, off, d, x);
  endtask

  // Register read and compare
  task automatic rdc(input string n, input logic [11:0] off, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, off, 32'h0, x);
    chk(n, exp, x);
  endtask

  // Three key writes
  task automatic keys(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wr(LK, {24'h0, a});
    wr(LK, {24'h0, b});
    wr(LK, {24'h0, c});
  endtask

  // Expected active fields from one trim code and range bit
  function automatic logic [31:0] fld(input logic [7:0] code, input logic rng);
    fld = {23'h0, code[7:5], code[4:0], rng};
  endfunction

  // Sets the select level and compares the active fields
  task automatic osc_chk(input logic sel, input logic [31:0] exp);
    osc_sel <= sel;
    repeat (2) @(posedge mclk);
    chk("osc_fields", exp, {23'h0, osc_coarse, osc_fine, osc_low_range});
  endtask

  // Reset state and factory load
  task automatic t_reset();
    chk("unlock_state", 32'h0, {31'h0, unlock_state});
    rdc("lock_key", LK, 32'h0);
    rdc("trim", TR, 32'h01FF01C3);
    osc_chk(1'b0, fld(8'hC3, 1'b1));
    osc_chk(1'b1, fld(8'hFF, 1'b1));
  endtask

  // Locked trim write is dropped
  task automatic t_locked();
    wr(TR, 32'h0);
    rdc("trim_locked", TR, 32'h01FF01C3);
    osc_chk(1'b0, fld(8'hC3, 1'b1));
  endtask

  // Broken sequences never unlock
  task automatic t_abort();
    logic [7:0] s [4][3];
    s = '{'{8'h59, 8'h17, 8'h88}, '{8'h16, 8'h59, 8'h88}, '{8'h59, 8'h88, 8'h16},
          '{8'h59, 8'h16, 8'h89}};
    for (int i = 0; i < 4; i++)
    begin
      keys(s[i][0], s[i][1], s[i][2]);
      @(posedge mclk);
      chk("unlock_bad", 32'h0, {31'h0, unlock_state});
    end
    wr(LK, 32'h59);
    wr(12'h104, 32'h16);
    keys(8'h16, 8'h88, 8'h16);
    wr(LK, 32'h59);
    wr(TR, 32'h0);
    wr(LK, 32'h16);
    wr(LK, 32'h88);
    @(posedge mclk);
    chk("unlock_addr", 32'h0, {31'h0, unlock_state});
  endtask

  // Full sequence right after aborts opens the lock
  task automatic t_unlock();
    wr(LK, 32'h59);
    wr(LK, 32'h16);
    @(posedge mclk);
    chk("unlock_two", 32'h0, {31'h0, unlock_state});
    wr(LK, 32'h88);
    @(posedge mclk);
    chk("unlock_three", 32'h1, {31'h0, unlock_state});
    rdc("lock_key_open", LK, 32'h1);
  endtask

  // Trim writes while open, field placement
  task automatic t_trim();
    wr(TR, 32'hFFFFFFFF);
    rdc("trim_mask", TR, 32'h01FF01FF);
    wr(TR, 32'h01234A5B);
    rdc("trim_open", TR, 32'h0123005B);
    osc_chk(1'b0, fld(8'h5B, 1'b0));
    osc_chk(1'b1, fld(8'h23, 1'b1));
  endtask

  // Any lock key write relocks, unmapped reads give zero
  task automatic t_relock();
    wr(LK, 32'h12345600);
    @(posedge mclk);
    chk("relock", 32'h0, {31'h0, unlock_state});
    rdc("lock_key_shut", LK, 32'h0);
    wr(TR, 32'h0);
    rdc("trim_relocked", TR, 32'h0123005B);
    rdc("unmapped", 12'h104, 32'h0);
  endtask

  // Mid-run reset relocks and reloads the factory trim
  task automatic t_rereset();
    keys(8'h59, 8'h16, 8'h88);
    wr(TR, 32'h0);
    rdc("trim_cleared", TR, 32'h0);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("unlock_rst", 32'h0, {31'h0, unlock_state});
    rdc("trim_reload", TR, 32'h01FF01C3);
  endtask

  // Prints the counts and the verdict, then stops
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    factory_trim = 32'hFFFFA5C3;
    osc_sel = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_locked();
    t_abort();
    t_unlock();
    t_trim();
    t_relock();
    t_rereset();
    results();
  end
endmodule
